// *** rtl/ash_map.svh ***
`ifndef ASH_MAP_SVH
`define ASH_MAP_SVH
// Register byte offsets on the AXI4-Lite port.
`define ASH_OFF_INSTR 8'h00
`define ASH_OFF_RESULT 8'h04
`define ASH_OFF_STATUS 8'h08
`define ASH_OFF_CONFIG 8'h0c
// Instruction word fields, three bits per octal digit.
`define ASH_IW_TOP 15
`define ASH_IW_ZERO_HI 14
`define ASH_IW_ZERO_LO 12
`define ASH_IW_CLASS_HI 11
`define ASH_IW_CLASS_LO 9
`define ASH_IW_FUNC_HI 8
`define ASH_IW_FUNC_LO 6
`define ASH_IW_ADDR_HI 5
`define ASH_IW_ADDR_LO 0
`define ASH_IW_DATA_LO 16
// Status bit positions; the low eight follow the sense function numbers.
`define ASH_ST_FRAMING 0
`define ASH_ST_TX_FREE 1
`define ASH_ST_RX_FULL 2
`define ASH_ST_PARITY 4
`define ASH_ST_OPT_IN 6
`define ASH_ST_OVERFLOW 7
`define ASH_ST_OUT_CONN 8
`define ASH_ST_IN_CONN 9
`define ASH_ST_OPT_OUT 10
// Result register fields.
`define ASH_RS_SENSE 16
`define ASH_RS_ACCEPT 17
`define ASH_RS_CLEARED 18
// Configuration fields and reset value.
`define ASH_CF_LEN_LO 0
`define ASH_CF_LEN_HI 1
`define ASH_CF_PARITY_ON 2
`define ASH_CF_EVEN 3
`define ASH_CF_TWO_STOP 4
`define ASH_CFG_RESET 5'h03
// Timing.
`define ASH_CLK_HZ 100000000
`define ASH_BAUD 9600
`define ASH_OVERSAMPLE 16
`define ASH_DEV_ADDR 6'h02
`endif

// *** rtl/ash_pkg.sv ***
`default_nettype none
package ash_pkg;
  typedef enum logic [2:0]
  {
    ASH_CLS_EXT = 3'h0,
    ASH_CLS_SENSE = 3'h1,
    ASH_CLS_IN = 3'h2,
    ASH_CLS_OUT = 3'h3
  } ash_class_t;
  typedef enum logic [4:0]
  {
    ASH_S_IDLE = 5'h01,
    ASH_S_START = 5'h02,
    ASH_S_DATA = 5'h04,
    ASH_S_PARITY = 5'h08,
    ASH_S_STOP = 5'h10
  } ash_state_t;
  typedef logic [7:0] ash_char_t;
endpackage
`default_nettype wire

// *** rtl/ash_serial_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ash_map.svh"
module ash_serial_host #(
  parameter logic [5:0] DEV_ADDR = `ASH_DEV_ADDR,
  parameter int CLK_HZ = `ASH_CLK_HZ,
  parameter int BAUD = `ASH_BAUD
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ash_pkg::ash_char_t chan_out_data,
  input wire logic chan_out_strobe,
  input wire logic chan_in_strobe,
  output ash_pkg::ash_char_t chan_in_data,
  output logic chan_out_req,
  output logic chan_in_req,
  input wire logic option_status_input,
  output logic option_control_output,
  input wire logic rxd,
  output logic txd,
  output logic irq_out_ready,
  output logic irq_in_ready,
  output logic irq_error
);
  import ash_pkg::*;

  // Oversampling divider; the rate is a build-time choice, as on the jumpered original.
  localparam int DIV = CLK_HZ / (BAUD * `ASH_OVERSAMPLE);
  localparam logic [15:0] DIV_LAST = 16'(DIV - 1);

  logic [15:0] div_cnt_r;
  logic tick;
  logic aw_held_r, w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write, aw_take, w_take, ar_take;
  logic [4:0] cfg_r;
  logic [31:0] result_r;
  logic [10:0] status;
  logic transmit_buffer_free_r, receive_buffer_full_r;
  logic framing_error_flag_r, parity_error_flag_r, overflow_flag_r;
  logic out_conn_r, in_conn_r;
  ash_char_t tx_buf_r, rx_buf_r, tx_sh_r, rx_sh_r;
  ash_state_t tx_state_r, rx_state_r;
  logic [3:0] tx_phase_r, rx_phase_r;
  logic [2:0] tx_idx_r, rx_idx_r;
  logic tx_stop2_r, rx_par_r;
  logic rx_done;
  logic tx_take;
  logic [2:0] last_idx;
  ash_char_t len_mask;
  logic instr_hit;
  ash_class_t iclass;
  logic [2:0] ifunc;
  logic is_init, out_load, rx_read, host_out, host_in, host_clear;
  logic tx_free_q, rx_full_q, err_q;

  // Character length select gives the index of the last data bit and a data mask.
  // length select
  assign last_idx = 3'h4 + {1'b0, cfg_r[`ASH_CF_LEN_HI:`ASH_CF_LEN_LO]};
  assign len_mask = ash_char_t'(8'hff >> (3'h7 - last_idx));

  // Free-running oversample tick.
  // fixed rate
  always_ff @(posedge aclk)
  begin
    if (!aresetn || div_cnt_r == DIV_LAST)
      div_cnt_r <= 16'h0000;
    else
      div_cnt_r <= div_cnt_r + 16'h0001;
  end
  assign tick = (div_cnt_r == DIV_LAST);

  // AXI handshakes; a write executes once both address and data are held.
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held_r <= 1'b0;
      if (w_take)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      else if (do_write)
        w_held_r <= 1'b0;
      s_axi_awready <= !(aw_take || (aw_held_r && !do_write));
      s_axi_wready <= !(w_take || (w_held_r && !do_write));
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        if (awaddr_r == `ASH_OFF_INSTR || awaddr_r == `ASH_OFF_CONFIG)
          s_axi_bresp <= 2'h0;
        else
          s_axi_bresp <= 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Instruction decode of the word written to the instruction register.
  // address match
  assign instr_hit = do_write && awaddr_r == `ASH_OFF_INSTR && wdata_r[`ASH_IW_TOP]
    && wdata_r[`ASH_IW_ZERO_HI:`ASH_IW_ZERO_LO] == 3'h0
    && wdata_r[`ASH_IW_ADDR_HI:`ASH_IW_ADDR_LO] == DEV_ADDR;
  assign iclass = ash_class_t'(wdata_r[`ASH_IW_CLASS_HI:`ASH_IW_CLASS_LO]);
  assign ifunc = wdata_r[`ASH_IW_FUNC_HI:`ASH_IW_FUNC_LO];
  assign is_init = instr_hit && iclass == ASH_CLS_EXT && ifunc == 3'h4;
  assign host_out = instr_hit && iclass == ASH_CLS_OUT && ifunc <= 3'h2;
  assign host_clear = ifunc == 3'h5 || ifunc == 3'h6;
  assign host_in = instr_hit && iclass == ASH_CLS_IN && (ifunc <= 3'h2 || host_clear);
  // A full transmit buffer refuses a new load rather than losing the pending character.
  assign out_load = (host_out || (chan_out_strobe && out_conn_r)) && transmit_buffer_free_r;
  assign rx_read = host_in || (chan_in_strobe && in_conn_r);

  // Status word; its low byte is indexed by the sense function code.
  assign status = {option_control_output, in_conn_r, out_conn_r, overflow_flag_r, option_status_input,
    1'b0, parity_error_flag_r, 1'b0, receive_buffer_full_r, transmit_buffer_free_r, framing_error_flag_r};

  // Configuration register; only byte lane 0 carries fields.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_r <= `ASH_CFG_RESET;
    else if (do_write && awaddr_r == `ASH_OFF_CONFIG && wstrb_r[0])
      cfg_r <= wdata_r[4:0];
  end

  // Channel connections and the option control line.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || is_init)
    begin
      out_conn_r <= 1'b0;
      in_conn_r <= 1'b0;
      option_control_output <= 1'b0;
    end
    else if (instr_hit && iclass == ASH_CLS_EXT)
    begin
      if (ifunc == 3'h0 || ifunc == 3'h1)
        out_conn_r <= 1'b1;
      if (ifunc == 3'h2 || ifunc == 3'h5)
        in_conn_r <= 1'b1;
      if (ifunc == 3'h6)
        option_control_output <= 1'b1;
      else if (ifunc == 3'h7)
        option_control_output <= 1'b0;
    end
  end

  // Result of the last instruction: bus word, sense answer and acceptance.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result_r <= 32'h0000_0000;
    else if (do_write && awaddr_r == `ASH_OFF_INSTR)
    begin
      result_r <= 32'h0000_0000;
      if (instr_hit)
      begin
        result_r[`ASH_RS_ACCEPT] <= !(iclass == ASH_CLS_OUT && !out_load);
        if (iclass == ASH_CLS_SENSE)
          result_r[`ASH_RS_SENSE] <= status[ifunc];
        if (host_in)
        begin
          result_r[15:0] <= {8'h00, rx_buf_r & len_mask};
          result_r[`ASH_RS_CLEARED] <= host_clear;
        end
      end
    end
  end

  // Transmit buffer and its free flag.
  // load and take
  always_ff @(posedge aclk)
  begin
    if (!aresetn || is_init)
    begin
      transmit_buffer_free_r <= 1'b1;
      tx_buf_r <= 8'h00;
    end
    else if (out_load)
    begin
      transmit_buffer_free_r <= 1'b0;
      tx_buf_r <= (host_out ? wdata_r[`ASH_IW_DATA_LO +: 8] : chan_out_data) & len_mask;
    end
    else if (tx_take)
      transmit_buffer_free_r <= 1'b1;
  end
  assign tx_take = tx_state_r == ASH_S_IDLE && !transmit_buffer_free_r;

  // Transmit shifter; each bit lasts sixteen oversample ticks.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || is_init)
    begin
      tx_state_r <= ASH_S_IDLE;
      txd <= 1'b1;
      tx_phase_r <= 4'h0;
      tx_idx_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_stop2_r <= 1'b0;
    end
    else
    begin
      case (tx_state_r)
        ASH_S_IDLE:
        begin
          if (tx_take)
          begin
            tx_sh_r <= tx_buf_r;
            tx_state_r <= ASH_S_START;
            txd <= 1'b0;
            tx_phase_r <= 4'h0;
          end
        end
        default:
        begin
          if (tick)
          begin
            tx_phase_r <= tx_phase_r + 4'h1;
            if (tx_phase_r == 4'hf)
            begin
              case (tx_state_r)
                ASH_S_START:
                begin
                  tx_state_r <= ASH_S_DATA;
                  tx_idx_r <= 3'h0;
                  txd <= tx_sh_r[0];
                end
                ASH_S_DATA:
                begin
                  if (tx_idx_r == last_idx)
                  begin
                    if (cfg_r[`ASH_CF_PARITY_ON])
                    begin
                      tx_state_r <= ASH_S_PARITY;
                      txd <= (^tx_sh_r) ^ !cfg_r[`ASH_CF_EVEN];
                    end
                    else
                    begin
                      tx_state_r <= ASH_S_STOP;
                      txd <= 1'b1;
                      tx_stop2_r <= cfg_r[`ASH_CF_TWO_STOP];
                    end
                  end
                  else
                  begin
                    tx_idx_r <= tx_idx_r + 3'h1;
                    txd <= tx_sh_r[tx_idx_r + 3'h1];
                  end
                end
                ASH_S_PARITY:
                begin
                  tx_state_r <= ASH_S_STOP;
                  txd <= 1'b1;
                  tx_stop2_r <= cfg_r[`ASH_CF_TWO_STOP];
                end
                default:
                begin
                  if (tx_stop2_r)
                    tx_stop2_r <= 1'b0;
                  else
                    tx_state_r <= ASH_S_IDLE;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  // Receiver; the start bit is confirmed at mid-bit, later bits sampled at their centres.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || is_init)
    begin
      rx_state_r <= ASH_S_IDLE;
      rx_phase_r <= 4'h0;
      rx_idx_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
    end
    else
    begin
      case (rx_state_r)
        ASH_S_IDLE:
        begin
          rx_phase_r <= 4'h0;
          if (!rxd)
            rx_state_r <= ASH_S_START;
        end
        ASH_S_START:
        begin
          if (tick)
          begin
            rx_phase_r <= rx_phase_r + 4'h1;
            if (rx_phase_r == 4'h7)
            begin
              rx_phase_r <= 4'h0;
              rx_idx_r <= 3'h0;
              rx_sh_r <= 8'h00;
              rx_state_r <= rxd ? ASH_S_IDLE : ASH_S_DATA;
            end
          end
        end
        default:
        begin
          if (tick)
          begin
            rx_phase_r <= rx_phase_r + 4'h1;
            if (rx_phase_r == 4'hf)
            begin
              case (rx_state_r)
                ASH_S_DATA:
                begin
                  rx_sh_r[rx_idx_r] <= rxd;
                  rx_idx_r <= rx_idx_r + 3'h1;
                  if (rx_idx_r == last_idx)
                    rx_state_r <= cfg_r[`ASH_CF_PARITY_ON] ? ASH_S_PARITY : ASH_S_STOP;
                end
                ASH_S_PARITY:
                begin
                  rx_par_r <= rxd;
                  rx_state_r <= ASH_S_STOP;
                end
                default:
                  rx_state_r <= ASH_S_IDLE;
              endcase
            end
          end
        end
      endcase
    end
  end
  assign rx_done = rx_state_r == ASH_S_STOP && tick && rx_phase_r == 4'hf;

  // Received character buffer and its flags; an arrival wins over a same-cycle read.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || is_init)
    begin
      receive_buffer_full_r <= 1'b0;
      rx_buf_r <= 8'h00;
      framing_error_flag_r <= 1'b0;
      parity_error_flag_r <= 1'b0;
      overflow_flag_r <= 1'b0;
    end
    else if (rx_done)
    begin
      receive_buffer_full_r <= 1'b1;
      rx_buf_r <= rx_sh_r;
      framing_error_flag_r <= !rxd;
      parity_error_flag_r <= cfg_r[`ASH_CF_PARITY_ON] && ((^(rx_sh_r & len_mask)) ^ rx_par_r ^ !cfg_r[`ASH_CF_EVEN]);
      if (receive_buffer_full_r && !rx_read)
        overflow_flag_r <= 1'b1;
    end
    else if (rx_read)
    begin
      receive_buffer_full_r <= 1'b0;
      overflow_flag_r <= 1'b0;
    end
  end

  // Channel requests and the character offered to the channel.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chan_out_req <= 1'b0;
      chan_in_req <= 1'b0;
      chan_in_data <= 8'h00;
    end
    else
    begin
      chan_out_req <= out_conn_r && transmit_buffer_free_r && !out_load && !is_init;
      chan_in_req <= in_conn_r && receive_buffer_full_r && !rx_read && !is_init;
      chan_in_data <= rx_buf_r & len_mask;
    end
  end

  // Interrupt lines pulse for one cycle on each rising condition.
  // three lines
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_free_q <= 1'b1;
      rx_full_q <= 1'b0;
      err_q <= 1'b0;
      irq_out_ready <= 1'b0;
      irq_in_ready <= 1'b0;
      irq_error <= 1'b0;
    end
    else
    begin
      tx_free_q <= transmit_buffer_free_r;
      rx_full_q <= receive_buffer_full_r;
      err_q <= framing_error_flag_r || overflow_flag_r;
      irq_out_ready <= transmit_buffer_free_r && !tx_free_q;
      irq_in_ready <= receive_buffer_full_r && !rx_full_q;
      irq_error <= (framing_error_flag_r || overflow_flag_r) && !err_q;
    end
  end

  // Read channel; reads have no side effects, so polling status is harmless.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !(ar_take || (s_axi_rvalid && !s_axi_rready));
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        if (s_axi_araddr == `ASH_OFF_RESULT)
          s_axi_rdata <= result_r;
        else if (s_axi_araddr == `ASH_OFF_STATUS)
          s_axi_rdata <= {21'h000000, status};
        else if (s_axi_araddr == `ASH_OFF_CONFIG)
          s_axi_rdata <= {27'h0000000, cfg_r};
        else if (s_axi_araddr == `ASH_OFF_INSTR)
          s_axi_rdata <= 32'h0000_0000;
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // ash_serial_host
`default_nettype wire

// *** tb/ash_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pin-level timing of the bus answers, channel requests and interrupt pulses.
module ash_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic chan_out_strobe,
  input wire logic chan_in_strobe,
  input wire logic chan_out_req,
  input wire logic chan_in_req,
  input wire logic irq_out_ready,
  input wire logic irq_in_ready,
  input wire logic irq_error
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_out_irq_pulse: assert property (irq_out_ready |=> !irq_out_ready)
    else $error("transmit interrupt longer than one cycle");
  a_in_irq_pulse: assert property (irq_in_ready |=> !irq_in_ready)
    else $error("receive interrupt longer than one cycle");
  a_err_irq_pulse: assert property (irq_error |=> !irq_error)
    else $error("error interrupt longer than one cycle");
  a_out_req_drop: assert property (chan_out_strobe && chan_out_req |-> ##[1:2] !chan_out_req)
    else $error("channel output request stayed up after a load");
  a_in_req_drop: assert property (chan_in_strobe && chan_in_req |-> ##[1:3] !chan_in_req)
    else $error("channel input request stayed up after a take");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data waits");
  c_err_irq: cover property (irq_error);
  c_chan_take: cover property (chan_in_strobe && chan_in_req);
  c_chan_load: cover property (chan_out_strobe && chan_out_req);
endmodule // ash_props
bind ash_serial_host ash_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .chan_out_strobe, .chan_in_strobe, .chan_out_req, .chan_in_req, .irq_out_ready, .irq_in_ready, .irq_error);
`default_nettype wire

// *** tb/ash_term.sv ***
`timescale 1ns/1ps
`default_nettype none
// Far-end terminal: frames characters onto the receive line and decodes the transmit line.
module ash_term #(
  parameter int BIT = 16
) (
  input wire logic aclk,
  input wire logic txd,
  output logic rxd,
  output logic [7:0] got,
  output logic got_ok,
  output logic got_stb
);
  int nb = 8;
  logic par_on = 1'b0;
  logic par_even = 1'b0;
  logic two = 1'b0;
  // no echo; the line rests at mark between frames.
  initial
  begin
    rxd = 1'b1;
    got_stb = 1'b0;
  end
  task automatic send(input logic [7:0] c, input logic stop, input logic bad);
    logic p;
    p = ^(c & (8'hff >> (8 - nb))) ^ ~par_even ^ bad;
    rxd <= 1'b0;
    repeat (BIT) @(posedge aclk);
    for (int i = 0; i < nb; i++)
    begin
      rxd <= c[i];
      repeat (BIT) @(posedge aclk);
    end
    if (par_on)
    begin
      rxd <= p;
      repeat (BIT) @(posedge aclk);
    end
    rxd <= stop;
    repeat (BIT) @(posedge aclk);
    rxd <= 1'b1;
  endtask
  // Sampling at bit centres; a missing second stop only shows when frames run back to back.
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge aclk);
    got_ok = !txd;
    got = 8'h00;
    for (int i = 0; i < nb; i++)
    begin
      repeat (BIT) @(posedge aclk);
      got[i] = txd;
    end
    if (par_on)
    begin
      repeat (BIT) @(posedge aclk);
      got_ok &= (txd == (^got ^ ~par_even));
    end
    repeat (two ? 2 : 1)
    begin
      repeat (BIT) @(posedge aclk);
      got_ok &= txd;
    end
    got_stb <= 1'b1;
    @(posedge aclk);
    got_stb <= 1'b0;
  end
endmodule // ash_term
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ash_map.svh"
`define CHK(n, e, s) begin logic [65:0] ce; ce = 66'(e); checked++; if (ce !== (s)) begin fails++; $display("ERROR %s expected %h seen %h", n, ce, s); end end
module tb;
  import ash_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, got, ch;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic cos = 1'b0, cis = 1'b0, opt_in = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [3:0] wstrb = 4'hf;
  ash_char_t cod = 8'h00, cid;
  logic awready, wready, bvalid, arready, rvalid, cor, cir, opt_out, rxd, txd, iqo, iqi, iqe, got_ok, got_stb;
  logic [1:0] bresp, rresp;
  logic [65:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [8:0] exp_tx[$];
  int fails = 0, checked = 0, seed = 79, nin = 0, nerr = 0, nout = 0, n;
  logic [2:0] ext_f[8] = '{3'h6, 3'h0, 3'h2, 3'h4, 3'h1, 3'h5, 3'h7, 3'h4};
  logic [2:0] ext_s[8] = '{3'h4, 3'h5, 3'h7, 3'h0, 3'h1, 3'h3, 3'h3, 3'h0};
  logic [2:0] sen_f[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
  logic sen_e[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [2:0] in_f[5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  logic [2:0] out_f[3] = '{3'h1, 3'h2, 3'h0};
  logic [4:0] c;
  always #5 aclk = ~aclk;
  ash_serial_host #(.BAUD(6250000)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chan_out_data(cod), .chan_out_strobe(cos), .chan_in_strobe(cis), .chan_in_data(cid),
    .chan_out_req(cor), .chan_in_req(cir), .option_status_input(opt_in), .option_control_output(opt_out),
    .rxd(rxd), .txd(txd), .irq_out_ready(iqo), .irq_in_ready(iqi), .irq_error(iqe));
  ash_term term (.aclk(aclk), .txd(txd), .rxd(rxd), .got(got), .got_ok(got_ok), .got_stb(got_stb));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic lim(input int k, input int top);
    if (k >= top)
    begin
      fails++;
      $display("ERROR wait limit expected %0d seen %0d", top - 1, k);
      close_out();
    end
  endtask
  // Address and data are offered together; the response is awaited with bready held up.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k = 0;
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      k++;
    end
    while (bvalid !== 1'b1 && k < 300);
    lim(k, 300);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r,
    output logic [31:0] d);
    int k = 0;
    exp_r.push_back({r, m, e & m});
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      k++;
    end
    while (rvalid !== 1'b1 && k < 300);
    d = rdata;
    lim(k, 300);
  endtask
  task automatic ex(input logic [2:0] cl, input logic [2:0] f, input logic [7:0] d);
    wr(`ASH_OFF_INSTR, {8'h00, d, 4'h8, cl, f, `ASH_DEV_ADDR}, 2'h0);
  endtask
  task automatic res(input logic [31:0] m, input logic [31:0] e);
    rd(`ASH_OFF_RESULT, m, e, 2'h0, v);
  endtask
  task automatic wait_st(input int b, input logic lv);
    int k = 0;
    do
    begin
      rd(`ASH_OFF_STATUS, 32'h0, 32'h0, 2'h0, v);
      k++;
    end
    while (v[b] !== lv && k < 400);
    lim(k, 400);
  endtask
  task automatic cfg(input logic [4:0] cv);
    wr(`ASH_OFF_CONFIG, {27'h0, cv}, 2'h0);
    term.nb = 5 + cv[1:0];
    term.par_on = cv[2];
    term.par_even = cv[3];
    term.two = cv[4];
  endtask
  task automatic drain();
    for (n = 0; exp_tx.size() > 0 && n < 3000; n++)
      @(posedge aclk);
    lim(n, 3000);
  endtask
  // Every result is matched against the oldest note left by the driver.
  always @(posedge aclk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
    begin
      `CHK("read data", exp_r[0][31:0], rdata & exp_r[0][63:32])
      `CHK("read resp", exp_r[0][65:64], rresp)
      void'(exp_r.pop_front());
    end
    if (bvalid === 1'b1 && bready === 1'b1)
      `CHK("write resp", exp_b.pop_front(), bresp)
    if (got_stb === 1'b1)
      `CHK("serial char", exp_tx.pop_front(), {got_ok, got})
    nin += (iqi === 1'b1);
    nerr += (iqe === 1'b1);
    nout += (iqo === 1'b1);
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`ASH_OFF_STATUS, 32'h000007ff, 32'h00000002, 2'h0, v);
    rd(`ASH_OFF_CONFIG, 32'h0000001f, 32'h00000003, 2'h0, v);
    rd(`ASH_OFF_INSTR, 32'hffffffff, 32'h00000000, 2'h0, v);
    rd(8'h10, 32'hffffffff, 32'h00000000, 2'h2, v);
    wr(8'h14, 32'h0000ffff, 2'h2);
    $display("test registers done");
    // connect, initialize and option codes in turn
    foreach (ext_f[i])
    begin
      ex(3'h0, ext_f[i], 8'h00);
      rd(`ASH_OFF_STATUS, 32'h00000702, {21'h0, ext_s[i], 8'h02}, 2'h0, v);
      `CHK("option line", ext_s[i][2], opt_out)
    end
    opt_in <= 1'b1;
    foreach (sen_f[i])
    begin
      ex(3'h1, sen_f[i], 8'h00);
      res(32'h00030000, {14'h0, 1'b1, sen_e[i], 16'h0});
    end
    // foreign address or bad top bits leave the block untouched
    ch = 8'($random(seed));
    if (ch[5:0] == `ASH_DEV_ADDR)
      ch[0] = ~ch[0];
    wr(`ASH_OFF_INSTR, {16'h0, 4'h8, 3'h0, 3'h6, ch[5:0]}, 2'h0);
    res(32'h00020000, 32'h0);
    wr(`ASH_OFF_INSTR, {16'h0, 4'h0, 3'h0, 3'h6, `ASH_DEV_ADDR}, 2'h0);
    res(32'h00020000, 32'h0);
    `CHK("option line", 1'b0, opt_out)
    $display("test commands done");
    foreach (in_f[i])
    begin
      c = 5'(i * 7);
      cfg(c);
      ch = 8'($random(seed));
      term.send(ch, 1'b1, 1'b0);
      wait_st(`ASH_ST_RX_FULL, 1'b1);
      ex(3'h2, in_f[i], 8'h00);
      res(32'h0006ffff, {13'h0, in_f[i][2], 1'b1, 9'h0, ch & (8'hff >> (3 - c[1:0]))});
      rd(`ASH_OFF_STATUS, 32'h00000095, 32'h0, 2'h0, v);
    end
    $display("test receive done");
    // framing on a break, parity and overflow
    cfg(5'h07);
    term.send(8'h00, 1'b0, 1'b0);
    wait_st(`ASH_ST_RX_FULL, 1'b1);
    ex(3'h1, 3'h0, 8'h00);
    res(32'h00010000, 32'h00010000);
    ex(3'h2, 3'h1, 8'h00);
    res(32'h0000ffff, 32'h0);
    term.send(8'($random(seed)), 1'b1, 1'b1);
    wait_st(`ASH_ST_RX_FULL, 1'b1);
    rd(`ASH_OFF_STATUS, 32'h00000011, 32'h00000010, 2'h0, v);
    ex(3'h1, 3'h4, 8'h00);
    res(32'h00010000, 32'h00010000);
    term.send(8'($random(seed)), 1'b1, 1'b0);
    wait_st(`ASH_ST_OVERFLOW, 1'b1);
    ex(3'h1, 3'h7, 8'h00);
    res(32'h00010000, 32'h00010000);
    ex(3'h2, 3'h1, 8'h00);
    rd(`ASH_OFF_STATUS, 32'h00000084, 32'h0, 2'h0, v);
    $display("test errors done");
    // back-to-back characters with two stops, then a refused load
    cfg(5'h1e);
    foreach (out_f[i])
    begin
      wait_st(`ASH_ST_TX_FREE, 1'b1);
      ch = 8'($random(seed));
      exp_tx.push_back({1'b1, ch & 8'h7f});
      ex(3'h3, out_f[i], ch);
      res(32'h00020000, 32'h00020000);
    end
    ex(3'h3, 3'h0, 8'h55);
    res(32'h00020000, 32'h0);
    drain();
    $display("test transmit done");
    ex(3'h0, 3'h0, 8'h00);
    for (n = 0; cor !== 1'b1 && n < 300; n++)
      @(posedge aclk);
    lim(n, 300);
    ch = 8'($random(seed));
    exp_tx.push_back({1'b1, ch & 8'h7f});
    cod <= ch;
    cos <= 1'b1;
    @(posedge aclk);
    cos <= 1'b0;
    drain();
    ex(3'h0, 3'h2, 8'h00);
    ch = 8'($random(seed));
    term.send(ch, 1'b1, 1'b0);
    for (n = 0; cir !== 1'b1 && n < 300; n++)
      @(posedge aclk);
    lim(n, 300);
    @(posedge aclk);
    `CHK("channel char", ch & 8'h7f, cid)
    cis <= 1'b1;
    @(posedge aclk);
    cis <= 1'b0;
    rd(`ASH_OFF_STATUS, 32'h00000004, 32'h0, 2'h0, v);
    $display("test channel done");
    `CHK("input interrupts", 8, nin)
    `CHK("error interrupts", 2, nerr)
    `CHK("output interrupts", 1'b1, nout > 0)
    close_out();
  end
endmodule // tb
`default_nettype wire
